// ### pmc_defs.svh
// Summary of operation
// - idle halts instruction execution until reset or interrupt.
// - in idle peripherals stay clocked; their interrupts restart the processor.
// - idle stops processor, memories with controllers, and internal buses.
// - power-down stops the main oscillator and withholds all internal clocks.
// - power-down keeps all state and holds output pins static.
// - power-down ends on reset or a clockless wake interrupt.
// - rtc runs in power-down only when clocked from the 32 kHz source.
// - deep power-down unpowers all but rtc, i/o, memory and 32 kHz oscillator.
// - memory and 32 kHz oscillator each have their own off control.
// - only chosen memory and three general registers survive deep power-down.
// - leaving deep power-down needs a full chip reset.
// - rtc supply comes from core supply when present, else battery.
// - each peripheral has its own off control, in active and idle.
// - divider gives full, half and quarter processor clock rate.
// - after reset the divider selects quarter rate.
// - pll stays active during idle since it feeds the divider.
// - three external interrupts, each edge or level sensitive.
// - each external interrupt individually enables wake from both power-downs.
// - capture interrupts never wake the device from power-down.
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define REG_MODE 8'h00
`define REG_PERIPH_PWR 8'h04
`define REG_DIV 8'h08
`define REG_EXT_CFG 8'h0c
`define REG_EXT_FLAG 8'h10
`define REG_STATUS 8'h14
`define REG_GP0 8'h18
`define REG_GP1 8'h1c
`define REG_GP2 8'h20
`define MODE_IDLE_BIT 0
`define MODE_PDOWN_BIT 1
`define MODE_DEEP_BIT 2
`define CFG_EDGE_LSB 0
`define CFG_POL_LSB 4
`define CFG_WAKE_LSB 8
`define CFG_SRAM_KEEP_BIT 16
`define CFG_OSC32_KEEP_BIT 17
`define CFG_RTC_EXT_BIT 18
`define DIV_QUARTER 2'h0
`define DIV_FULL 2'h1
`define DIV_HALF 2'h2
`define DIV_RST 2'h0
`define PERIPH_PWR_RST 16'hffff
`define PERIPH_MAX 16
`define EXT_COUNT 3
`define CLK_PERIOD_NS 8
`define OSC_STABLE_NS 500000
`define OSC_STABLE_CYCLES ((`OSC_STABLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### power_pkg.sv
`default_nettype none
package power_pkg;
	typedef enum logic [2:0] {RUNNING, IDLING, POWERED_DOWN, OSC_SETTLING, DEEP_DOWN} mode_type;
	typedef struct packed {
		mode_type mode;
		logic [23:0] osc_cnt;
		logic [1:0] div_cnt;
		logic [1:0] div_sel;
		logic [15:0] periph_pwr;
		logic [2:0] edge_mode;
		logic [2:0] pol_high;
		logic [2:0] wake_en;
		logic sram_keep;
		logic osc32_keep;
		logic rtc_ext;
		logic [2:0] flag;
		logic [2:0] pin_s1;
		logic [2:0] pin_s2;
		logic [2:0] pin_prev;
		logic sup_s1;
		logic sup_s2;
		logic [2:0][31:0] gp;
		logic aw_have;
		logic [7:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic cpu_halt;
		logic core_clk_en;
		logic cpu_irq;
		logic pclk_en;
		logic [15:0] periph_clk_en;
		logic osc_en;
		logic pll_en;
		logic pins_hold;
		logic rtc_run;
		logic rtc_from_core;
		logic logic_pwr;
		logic sram_pwr;
		logic osc32_pwr;
		logic reset_req;
	} state_type;
endpackage
`default_nettype wire

// ### power_mode_and_pclk_control.sv
`include "pmc_defs.svh"
`default_nettype none
module power_mode_and_pclk_control #(
	parameter int N_PERIPH = `PERIPH_MAX,
	parameter int OSC_WAIT = `OSC_STABLE_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// pins and on-chip sources
	input wire logic [2:0] ext_int_pin,
	input wire logic core_supply_present,
	input wire logic [9:0] capture_irq,
	input wire logic periph_irq,
	input wire logic pll_running,
	// processor side
	output logic cpu_halt,
	output logic core_clk_en,
	output logic cpu_irq,
	// clocks and power
	output logic pclk_en,
	output logic [15:0] periph_clk_en,
	output logic osc_en,
	output logic pll_en,
	output logic pins_hold,
	output logic rtc_run,
	output logic rtc_supply_from_core,
	output logic logic_pwr_en,
	output logic sram_pwr_en,
	output logic osc32_pwr_en,
	output logic chip_reset_req
);

	initial begin
		if (N_PERIPH < 1 || N_PERIPH > `PERIPH_MAX)
			$error("N_PERIPH out of range");
		if (OSC_WAIT < 1 || OSC_WAIT >= (1 << 24))
			$error("OSC_WAIT out of range");
	end

	localparam logic [23:0] OSC_LAST = 24'(OSC_WAIT - 1);

	power_pkg::state_type s;
	power_pkg::state_type next_s;

	////////////////////////////////////////////////////////////////////////
	// register view

	function automatic logic [31:0] reg_word(input power_pkg::state_type r, input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			`REG_MODE: begin
				v[`MODE_IDLE_BIT] = (r.mode == power_pkg::IDLING);
				v[`MODE_PDOWN_BIT] = (r.mode == power_pkg::POWERED_DOWN);
				v[`MODE_DEEP_BIT] = (r.mode == power_pkg::DEEP_DOWN);
			end
			`REG_PERIPH_PWR: v[15:0] = r.periph_pwr;
			`REG_DIV: v[1:0] = r.div_sel;
			`REG_EXT_CFG: begin
				v[`CFG_EDGE_LSB +: 3] = r.edge_mode;
				v[`CFG_POL_LSB +: 3] = r.pol_high;
				v[`CFG_WAKE_LSB +: 3] = r.wake_en;
				v[`CFG_SRAM_KEEP_BIT] = r.sram_keep;
				v[`CFG_OSC32_KEEP_BIT] = r.osc32_keep;
				v[`CFG_RTC_EXT_BIT] = r.rtc_ext;
			end
			`REG_EXT_FLAG: v[2:0] = r.flag;
			`REG_STATUS: v[2:0] = {pll_running, r.sup_s2, r.mode == power_pkg::OSC_SETTLING};
			`REG_GP0: v = r.gp[0];
			`REG_GP1: v = r.gp[1];
			`REG_GP2: v = r.gp[2];
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a inside {`REG_MODE, `REG_PERIPH_PWR, `REG_DIV, `REG_EXT_CFG, `REG_EXT_FLAG,
			`REG_STATUS, `REG_GP0, `REG_GP1, `REG_GP2};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [31:0] m;
		logic [2:0] req;
		logic [2:0] clr;
		logic [2:0] act;
		logic [2:0] act_prev;
		logic any_irq;
		logic wake;
		logic on;
		logic [1:0] term;
		m = 32'h0000_0000;
		req = 3'h0;
		clr = 3'h0;
		act = 3'h0;
		act_prev = 3'h0;
		any_irq = 1'b0;
		wake = 1'b0;
		on = 1'b0;
		term = 2'h3;
		next_s = s;
		next_s.pclk_en = 1'b0;
		// two-flop synchronisers
		next_s.pin_s1 = ext_int_pin;
		next_s.pin_s2 = s.pin_s1;
		next_s.pin_prev = s.pin_s2;
		next_s.sup_s1 = core_supply_present;
		next_s.sup_s2 = s.sup_s1;
		// write channel
		if (awvalid && s.awready) begin
			next_s.aw_have = 1'b1;
			next_s.awaddr = awaddr;
		end
		if (wvalid && s.wready) begin
			next_s.w_have = 1'b1;
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
		end
		if (s.bvalid && bready)
			next_s.bvalid = 1'b0;
		if (s.aw_have && s.w_have && !s.bvalid) begin
			m = reg_word(s, s.awaddr);
			for (int b = 0; b < 4; b++) begin
				if (s.wstrb[b])
					m[8*b +: 8] = s.wdata[8*b +: 8];
			end
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = mapped(s.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
			case (s.awaddr)
				`REG_MODE: req = s.wdata[2:0] & {3{s.wstrb[0]}};
				`REG_PERIPH_PWR: next_s.periph_pwr = m[15:0];
				`REG_DIV: next_s.div_sel = m[1:0];
				`REG_EXT_CFG: begin
					next_s.edge_mode = m[`CFG_EDGE_LSB +: 3];
					next_s.pol_high = m[`CFG_POL_LSB +: 3];
					next_s.wake_en = m[`CFG_WAKE_LSB +: 3];
					next_s.sram_keep = m[`CFG_SRAM_KEEP_BIT];
					next_s.osc32_keep = m[`CFG_OSC32_KEEP_BIT];
					next_s.rtc_ext = m[`CFG_RTC_EXT_BIT];
				end
				`REG_EXT_FLAG: clr = s.wdata[2:0] & {3{s.wstrb[0]}};
				`REG_GP0: next_s.gp[0] = m;
				`REG_GP1: next_s.gp[1] = m;
				`REG_GP2: next_s.gp[2] = m;
				default: m = 32'h0000_0000;
			endcase
		end
		next_s.awready = !next_s.aw_have && !next_s.bvalid;
		next_s.wready = !next_s.w_have && !next_s.bvalid;
		// read channel
		if (s.rvalid && rready)
			next_s.rvalid = 1'b0;
		if (arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = reg_word(s, araddr);
			next_s.rresp = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end
		next_s.arready = !next_s.rvalid;
		// external interrupt flags, a new edge beats a clear
		act = ~(s.pin_s2 ^ s.pol_high);
		act_prev = ~(s.pin_prev ^ s.pol_high);
		for (int i = 0; i < `EXT_COUNT; i++) begin
			if (s.edge_mode[i])
				next_s.flag[i] = (act[i] && !act_prev[i]) || (s.flag[i] && !clr[i]);
			else
				next_s.flag[i] = act[i];
		end
		// capture inputs interrupt only, never wake
		any_irq = (|s.flag) || periph_irq || (|capture_irq);
		wake = |(s.flag & s.wake_en);
		// mode sequencing
		unique case (s.mode)
			power_pkg::RUNNING: begin
				if (req[`MODE_DEEP_BIT])
					next_s.mode = power_pkg::DEEP_DOWN;
				else if (req[`MODE_PDOWN_BIT])
					next_s.mode = power_pkg::POWERED_DOWN;
				else if (req[`MODE_IDLE_BIT])
					next_s.mode = power_pkg::IDLING;
			end
			power_pkg::IDLING: begin
				if (any_irq)
					next_s.mode = power_pkg::RUNNING;
			end
			power_pkg::POWERED_DOWN: begin
				if (wake) begin
					next_s.mode = power_pkg::OSC_SETTLING;
					next_s.osc_cnt = 24'h00_0000;
				end
			end
			power_pkg::OSC_SETTLING: begin
				if (s.osc_cnt == OSC_LAST)
					next_s.mode = power_pkg::RUNNING;
				else
					next_s.osc_cnt = s.osc_cnt + 24'h00_0001;
			end
			power_pkg::DEEP_DOWN: begin
				if (wake)
					next_s.reset_req = 1'b1;
			end
		endcase
		// clocks follow the coming mode
		on = next_s.mode inside {power_pkg::RUNNING, power_pkg::IDLING};
		next_s.cpu_halt = next_s.mode != power_pkg::RUNNING;
		next_s.core_clk_en = next_s.mode == power_pkg::RUNNING;
		next_s.cpu_irq = any_irq;
		unique case (s.div_sel)
			`DIV_FULL: term = 2'h0;
			`DIV_HALF: term = 2'h1;
			default: term = 2'h3;
		endcase
		if (on) begin
			next_s.pclk_en = s.div_cnt >= term;
			next_s.div_cnt = (s.div_cnt >= term) ? 2'h0 : s.div_cnt + 2'h1;
		end else begin
			next_s.div_cnt = 2'h0;
		end
		for (int p = 0; p < `PERIPH_MAX; p++)
			next_s.periph_clk_en[p] = on && next_s.periph_pwr[p] && (p < N_PERIPH);
		next_s.osc_en = !(next_s.mode inside {power_pkg::POWERED_DOWN,
			power_pkg::DEEP_DOWN});
		next_s.pll_en = on;
		next_s.pins_hold = !on;
		next_s.rtc_run = on || next_s.rtc_ext;
		next_s.rtc_from_core = s.sup_s2;
		next_s.logic_pwr = next_s.mode != power_pkg::DEEP_DOWN;
		next_s.sram_pwr = next_s.logic_pwr || next_s.sram_keep;
		next_s.osc32_pwr = next_s.logic_pwr || next_s.osc32_keep;
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.gp <= s.gp;
			s.periph_pwr <= `PERIPH_PWR_RST;
			s.div_sel <= `DIV_RST;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.osc_en <= 1'b1;
			s.pll_en <= 1'b1;
			s.rtc_run <= 1'b1;
			s.logic_pwr <= 1'b1;
			s.sram_pwr <= 1'b1;
			s.osc32_pwr <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign cpu_halt = s.cpu_halt;
	assign core_clk_en = s.core_clk_en;
	assign cpu_irq = s.cpu_irq;
	assign pclk_en = s.pclk_en;
	assign periph_clk_en = s.periph_clk_en;
	assign osc_en = s.osc_en;
	assign pll_en = s.pll_en;
	assign pins_hold = s.pins_hold;
	assign rtc_run = s.rtc_run;
	assign rtc_supply_from_core = s.rtc_from_core;
	assign logic_pwr_en = s.logic_pwr;
	assign sram_pwr_en = s.sram_pwr;
	assign osc32_pwr_en = s.osc32_pwr;
	assign chip_reset_req = s.reset_req;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_idle_halt;
		s.mode == power_pkg::IDLING |-> cpu_halt && !core_clk_en;
	endproperty
	a_idle_halt: assert property (p_idle_halt) else $error("idle not halted");

	property p_idle_wake;
		s.mode == power_pkg::IDLING && periph_irq |=> s.mode == power_pkg::RUNNING && !cpu_halt;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle missed wake");

	property p_pdown_clocks;
		s.mode == power_pkg::POWERED_DOWN |-> !osc_en && !pclk_en && periph_clk_en == 16'h0000
			&& pins_hold && !pll_en;
	endproperty
	a_pdown_clocks: assert property (p_pdown_clocks) else $error("clock in power-down");

	property p_no_capture_wake;
		s.mode == power_pkg::POWERED_DOWN && !(|(s.flag & s.wake_en)) |=>
			s.mode == power_pkg::POWERED_DOWN;
	endproperty
	a_no_capture_wake: assert property (p_no_capture_wake) else $error("bad wake");

	property p_deep_reset;
		s.mode == power_pkg::DEEP_DOWN && |(s.flag & s.wake_en) |=> chip_reset_req
			&& !logic_pwr_en;
	endproperty
	a_deep_reset: assert property (p_deep_reset) else $error("no reset request");

	property p_reset_quarter;
		$rose(aresetn) |-> s.div_sel == `DIV_QUARTER;
	endproperty
	a_reset_quarter: assert property (p_reset_quarter) else $error("divider reset");

	property p_quarter_rate;
		(pclk_en && s.div_sel == `DIV_QUARTER) ##1
			(s.div_sel == `DIV_QUARTER && s.mode inside {power_pkg::RUNNING, power_pkg::IDLING})[*4]
			|-> pclk_en && !$past(pclk_en) && !$past(pclk_en, 2) && !$past(pclk_en, 3);
	endproperty
	a_quarter_rate: assert property (p_quarter_rate) else $error("quarter rate");

	property p_rtc_supply;
		core_supply_present [*3] |-> ##1 rtc_supply_from_core;
	endproperty
	a_rtc_supply: assert property (p_rtc_supply) else $error("rtc supply");

	property p_settle_hold;
		s.mode == power_pkg::OSC_SETTLING |-> osc_en && cpu_halt && periph_clk_en == 16'h0000;
	endproperty
	a_settle_hold: assert property (p_settle_hold) else $error("clocks early");

	c_idle_exit: cover property (s.mode == power_pkg::IDLING ##1 s.mode == power_pkg::RUNNING);
	c_pdown_wake: cover property (s.mode == power_pkg::OSC_SETTLING ##1 s.mode == power_pkg::RUNNING);
	c_deep_req: cover property ($rose(chip_reset_req));
	c_write: cover property (bvalid && bready && bresp == `RESP_OKAY);

endmodule // power_mode_and_pclk_control
`default_nettype wire

// ### periph_model.sv
`default_nettype none
module periph_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// clocking from the block
	input wire logic pclk_en,
	input wire logic clk_on,
	// bench control
	input wire logic arm,
	input wire logic [3:0] limit,
	// towards the block
	output logic irq,
	output logic [7:0] ticks
);
	timeunit 1ns;
	timeprecision 1ps;
	// timer advancing only on its own gated peripheral clock
	always_ff @(posedge aclk) begin
		if (!aresetn || !arm) begin
			ticks <= 8'h00;
		end else if (pclk_en && clk_on) begin
			ticks <= ticks + 8'h01;
		end
	end
	assign irq = arm && (ticks >= {4'h0, limit});
endmodule // periph_model
`default_nettype wire

// ### tb.sv
`include "pmc_defs.svh"
`default_nettype none
`define CHK(nm, exp, got) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		n_fail++; \
		$display("wrong value %s expected %h seen %h", nm, exp, got); \
	end \
end
`define WAIT(c) begin \
	samples_checked++; \
	for (wk = 0; wk < 200 && (c) !== 1'b1; wk++) @(posedge aclk); \
	if ((c) !== 1'b1) begin n_fail++; final_report(); end \
end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OSC_SIM = 8;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, arm, periph_irq, pll_running;
	logic [7:0] awaddr, araddr, ticks;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs, bs;
	logic [2:0] ext_int_pin;
	logic [9:0] capture_irq;
	logic core_supply_present, cpu_halt, core_clk_en, cpu_irq, pclk_en, osc_en, pll_en;
	logic pins_hold, rtc_run, rtc_supply_from_core, logic_pwr_en, sram_pwr_en;
	logic osc32_pwr_en, chip_reset_req;
	logic [15:0] periph_clk_en;
	logic [1:0] div_code [3] = '{`DIV_FULL, `DIV_HALF, 2'h3};
	int div_cnt [3] = '{32, 16, 8};
	int n_fail, samples_checked, wk, n;
	power_mode_and_pclk_control #(.OSC_WAIT(OSC_SIM)) dut_u (
		.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
		.rresp, .ext_int_pin, .core_supply_present, .capture_irq, .periph_irq, .pll_running,
		.cpu_halt, .core_clk_en, .cpu_irq, .pclk_en, .periph_clk_en, .osc_en, .pll_en,
		.pins_hold, .rtc_run, .rtc_supply_from_core, .logic_pwr_en, .sram_pwr_en,
		.osc32_pwr_en, .chip_reset_req
	);
	periph_model pm_u (
		.aclk, .aresetn, .pclk_en, .clk_on(periph_clk_en[0]), .arm, .limit(4'h3),
		.irq(periph_irq), .ticks
	);
	//////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		bit done;
		done = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 100 && !done; i++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			done = (bvalid === 1'b1);
			bs = bresp;
		end
		bready <= 1'b0;
		if (!done) begin n_fail++; final_report(); end
	endtask
	task automatic rdreg(input logic [7:0] a);
		int i;
		bit done;
		done = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 100 && !done; i++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			done = (rvalid === 1'b1);
			rd = rdata;
			rs = rresp;
		end
		rready <= 1'b0;
		if (!done) begin n_fail++; final_report(); end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		rdreg(a);
		`CHK(nm, e, rd)
	endtask
	task automatic count_pclk(input int cycles);
		int i;
		n = 0;
		repeat (4) @(posedge aclk);
		for (i = 0; i < cycles; i++) begin
			@(posedge aclk);
			if (pclk_en === 1'b1) n++;
		end
	endtask
	task automatic pin_pulse(input int p);
		@(posedge aclk);
		ext_int_pin[p] <= 1'b1;
		repeat (4) @(posedge aclk);
		ext_int_pin[p] <= 1'b0;
	endtask
	//////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, arm} = '0;
		{awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
		{ext_int_pin, capture_irq, core_supply_present, pll_running} = {3'h0, 10'h0, 2'h1};
		n_fail = 0;
		samples_checked = 0;
		do_reset();
		@(posedge aclk);
		`CHK("halt", 1'b0, cpu_halt)
		`CHK("pll", 1'b1, pll_en)
		rchk(`REG_DIV, 32'h0, "div reset");
		count_pclk(32);
		`CHK("quarter pulses", 8, n)
		for (int j = 0; j < 3; j++) begin
			wr(`REG_DIV, {30'h0, div_code[j]});
			count_pclk(32);
			`CHK("pulses", div_cnt[j], n)
		end
		$display("divider test done");
		rdreg(8'h40);
		`CHK("unmapped rresp", `RESP_SLVERR, rs)
		`CHK("unmapped rdata", 32'h0, rd)
		wr(8'h40, 32'hffff_ffff);
		`CHK("unmapped bresp", `RESP_SLVERR, bs)
		$display("unmapped test done");
		wr(`REG_EXT_CFG, 32'h0000_0077);
		wr(`REG_EXT_FLAG, 32'h7);
		for (int p = 0; p < 3; p++) begin
			pin_pulse(p);
			@(posedge aclk);
			`CHK("irq", 1'b1, cpu_irq)
			rchk(`REG_EXT_FLAG, 32'h1 << p, "ext flag");
			wr(`REG_EXT_FLAG, 32'h1 << p);
			rchk(`REG_EXT_FLAG, 32'h0, "ext flag clear");
		end
		$display("external interrupt test done");
		wr(`REG_PERIPH_PWR, 32'h0000_0f0f);
		@(posedge aclk);
		`CHK("periph clocks", 16'h0f0f, periph_clk_en)
		wr(`REG_MODE, 32'h1);
		`CHK("idle halt", 1'b1, cpu_halt)
		`CHK("idle core clock", 1'b0, core_clk_en)
		`CHK("idle pll", 1'b1, pll_en)
		`CHK("idle periph", 16'h0f0f, periph_clk_en)
		rchk(`REG_MODE, 32'h1, "mode idle");
		arm <= 1'b1;
		`WAIT(!cpu_halt)
		`CHK("ticks", 1'b1, ticks >= 8'h03)
		arm <= 1'b0;
		$display("idle test done");
		wr(`REG_EXT_CFG, 32'h0004_0177);
		wr(`REG_MODE, 32'h2);
		count_pclk(16);
		`CHK("pdown pclk", 0, n)
		`CHK("pdown osc", 1'b0, osc_en)
		`CHK("pdown periph", 16'h0000, periph_clk_en)
		`CHK("pdown pins", 1'b1, pins_hold)
		`CHK("pdown rtc", 1'b1, rtc_run)
		capture_irq <= 10'h3ff;
		pin_pulse(1);
		repeat (8) @(posedge aclk);
		`CHK("capture no wake", 1'b1, pins_hold)
		`CHK("pin1 no wake", 1'b0, osc_en)
		capture_irq <= 10'h000;
		pin_pulse(0);
		`WAIT(osc_en)
		`CHK("settling", 1'b1, cpu_halt)
		`WAIT(!cpu_halt)
		rchk(`REG_PERIPH_PWR, 32'h0000_0f0f, "kept");
		wr(`REG_EXT_FLAG, 32'h7);
		$display("power-down test done");
		core_supply_present <= 1'b1;
		`WAIT(rtc_supply_from_core)
		rchk(`REG_STATUS, 32'h6, "status");
		core_supply_present <= 1'b0;
		`WAIT(!rtc_supply_from_core)
		$display("supply test done");
		wr(`REG_GP0, 32'h5a5a_0001);
		wr(`REG_EXT_CFG, 32'h0001_0177);
		wr(`REG_MODE, 32'h4);
		repeat (2) @(posedge aclk);
		`CHK("deep logic", 1'b0, logic_pwr_en)
		`CHK("deep sram", 1'b1, sram_pwr_en)
		`CHK("deep osc32", 1'b0, osc32_pwr_en)
		pin_pulse(0);
		`WAIT(chip_reset_req)
		do_reset();
		rchk(`REG_GP0, 32'h5a5a_0001, "gp kept");
		rchk(`REG_DIV, 32'h0, "div lost");
		rchk(`REG_PERIPH_PWR, 32'h0000_ffff, "pwr lost");
		$display("deep power-down test done");
		final_report();
	end
endmodule // tb
`default_nettype wire
